// ### hdl/decoder_consts.svh
// Offsets, field positions, reset values and flag masks of the instruction decoder
`ifndef DECODER_CONSTS_SVH
`define DECODER_CONSTS_SVH
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_COUNT 12'h008
`define CTRL_BANK_MSB 3
`define CTRL_BANK_LSB 0
`define BANK_RESET 4'h0
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hF
`define PFX_SECOND 4'hF
`define FLAGS_NONE 5'h00
`define FLAGS_ARITH 5'h1F
`define FLAGS_ZN 5'h14
`define FLAGS_CZN 5'h15
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3
`endif

// ### hdl/decoder_pkg.sv
// Types shared by the instruction decoder
package decoder_pkg;
    typedef enum logic [5:0] {
        op_nop, add_accumulator_file, add_accumulator_file_carry, subtract_accumulator_from_file,
        subtract_accumulator_from_file_borrow, subtract_file_from_accumulator_borrow,
        and_accumulator_file, or_accumulator_file, xor_accumulator_file, complement_file,
        decrement_skip_zero, increment_skip_zero, decrement_skip_nonzero, increment_skip_nonzero,
        compare_skip_equal, compare_skip_greater, compare_skip_less,
        rotate_left_through_carry, rotate_right_through_carry, rotate_left_no_carry,
        rotate_right_no_carry, multiply_accumulator_file, file_to_file_move,
        bit_modify, bit_test_skip, literal_operation, unconditional_relative_branch,
        relative_call, conditional_branch, absolute_jump, absolute_call, subroutine_return, op_other
    } op_type;
    typedef enum logic [1:0] {st_first, st_operand} phase_type;
    // Flag mask order: bit0 carry, 1 digit_carry_flag, 2 zero, 3 overflow_flag, 4 negative
    typedef struct packed {
        logic valid;
        op_type op;
        logic to_file;
        logic [11:0] file_addr;
        logic [2:0] bit_pos;
        logic [7:0] literal;
        logic [11:0] move_dst;
        logic [19:0] target;
        logic fast;
        logic [4:0] flags;
        logic two_word;
        logic two_cycle;
        logic cond;
        logic use_pins;
        logic clr_prescaler;
    } decode_type;
    typedef struct packed {
        phase_type phase;
        logic flush;
        logic cond_pending;
        logic [15:0] held;
        decode_type out;
        logic [3:0] bank;
        logic [31:0] count;
        logic aw_rdy;
        logic w_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } core_type;
endpackage : decoder_pkg

// ### hdl/instruction_decoder.sv
// Instruction word decoder with AXI4-Lite control and status registers
`timescale 1ns/10ps
`default_nettype none
`include "decoder_consts.svh"

// Overview of operation
// - Destination bit 0 sends result to accumulator, 1 to the file register.
// - Bank bit 0 forces the access bank; 1 uses the bank selection register.
// - Low byte is the 8-bit file address, joined with the bank choice.
// - File-to-file move is two words: 12-bit source, then 1111-prefixed 12-bit destination.
// - Bit operations carry a 3-bit bit position above the bank bit.
// - Literal operations carry an 8-bit immediate in the low byte.
// - Jump and call: target bits 7:0 in word one, 19:8 in a 1111 word.
// - Call and return carry a fast bit passed to the context-save logic.
// - Fast bit 1 saves or restores shadows; 0 leaves them untouched.
// - Relative offsets are two's complement, added to the program counter.
// - Taken branches and true tests take two cycles, second one a no-operation.
// - A lone 1111-prefixed second word executes as a no-operation.
// - Read-modify-write on a port register reads the pin levels.
// - Writes to the first timer count clear its prescaler.
// - Add and add-with-carry: one cycle, all five arithmetic flags.
// - Subtract and subtract-with-borrow from file: one cycle, all five flags.
// - Accumulator minus file with borrow: one cycle, all five flags.
// - And, or, xor, complement: one cycle, zero and negative flags only.
// - Increment/decrement skips change no flags; one cycle, more when skipping.
// - Compare skips have no destination bit and change no flags.
// - Rotates through carry touch carry, zero, negative; others zero, negative.
// - Multiply has no destination bit and changes no status flags.
module instruction_decoder #(
    parameter logic [7:0] ACCESS_SPLIT = 8'h60,
    parameter logic [11:0] TIMER_ADDR = 12'hFD6,
    parameter logic [11:0] PORT_LO = 12'hF80,
    parameter logic [11:0] PORT_HI = 12'hF8F
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic [19:0] pc_next,
    input wire logic cond_true,
    output decoder_pkg::decode_type decoded
);
    import decoder_pkg::*;

    core_type st_r;
    core_type st_nxt;
    logic clean_first;

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [11:0] bank_addr(input logic a, input logic [7:0] f, input logic [3:0] bank);
        logic [3:0] hi;
        hi = (f < ACCESS_SPLIT) ? `ACCESS_LOW_BANK : `ACCESS_HIGH_BANK;
        bank_addr = a ? {bank, f} : {hi, f};
    endfunction : bank_addr

    function automatic logic is_port(input logic [11:0] addr);
        is_port = (addr >= PORT_LO) && (addr <= PORT_HI);
    endfunction : is_port

    function automatic decode_type decode_word(input logic [15:0] w, input logic [3:0] bank,
                                               input logic [19:0] pc);
        decode_type d;
        logic has_d;
        logic bitmod;
        d = '0;
        has_d = 1'b0;
        bitmod = 1'b0;
        d.valid = 1'b1;
        d.op = op_other;
        d.flags = `FLAGS_NONE;
        d.file_addr = bank_addr(w[8], w[7:0], bank);
        d.bit_pos = w[11:9];
        d.literal = w[7:0];
        unique casez (w[15:8])
            8'b0010_01??: begin d.op = add_accumulator_file; d.flags = `FLAGS_ARITH; has_d = 1'b1; end
            8'b0010_00??: begin d.op = add_accumulator_file_carry; d.flags = `FLAGS_ARITH; has_d = 1'b1; end
            8'b0101_11??: begin d.op = subtract_accumulator_from_file; d.flags = `FLAGS_ARITH; has_d = 1'b1; end
            8'b0101_10??: begin
                d.op = subtract_accumulator_from_file_borrow;
                d.flags = `FLAGS_ARITH;
                has_d = 1'b1;
            end
            8'b0101_01??: begin
                d.op = subtract_file_from_accumulator_borrow;
                d.flags = `FLAGS_ARITH;
                has_d = 1'b1;
            end
            8'b0001_01??: begin d.op = and_accumulator_file; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0001_00??: begin d.op = or_accumulator_file; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0001_10??: begin d.op = xor_accumulator_file; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0001_11??: begin d.op = complement_file; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0010_11??: begin d.op = decrement_skip_zero; d.cond = 1'b1; has_d = 1'b1; end
            8'b0011_11??: begin d.op = increment_skip_zero; d.cond = 1'b1; has_d = 1'b1; end
            8'b0100_11??: begin d.op = decrement_skip_nonzero; d.cond = 1'b1; has_d = 1'b1; end
            8'b0100_10??: begin d.op = increment_skip_nonzero; d.cond = 1'b1; has_d = 1'b1; end
            8'b0110_001?: begin d.op = compare_skip_equal; d.cond = 1'b1; end
            8'b0110_010?: begin d.op = compare_skip_greater; d.cond = 1'b1; end
            8'b0110_000?: begin d.op = compare_skip_less; d.cond = 1'b1; end
            8'b0011_01??: begin d.op = rotate_left_through_carry; d.flags = `FLAGS_CZN; has_d = 1'b1; end
            8'b0011_00??: begin d.op = rotate_right_through_carry; d.flags = `FLAGS_CZN; has_d = 1'b1; end
            8'b0100_01??: begin d.op = rotate_left_no_carry; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0100_00??: begin d.op = rotate_right_no_carry; d.flags = `FLAGS_ZN; has_d = 1'b1; end
            8'b0000_001?: d.op = multiply_accumulator_file;
            8'b1000_????, 8'b1001_????, 8'b0111_????: begin
                d.op = bit_modify;
                bitmod = 1'b1;
            end
            8'b1010_????, 8'b1011_????: begin
                d.op = bit_test_skip;
                d.cond = 1'b1;
            end
            8'b1100_????: begin
                d.op = file_to_file_move;
                d.file_addr = w[11:0];
                d.two_word = 1'b1;
            end
            8'b1101_0???: begin
                d.op = unconditional_relative_branch;
                d.target = pc + {{9{w[10]}}, w[10:0]};
                d.two_cycle = 1'b1;
            end
            8'b1101_1???: begin
                d.op = relative_call;
                d.target = pc + {{9{w[10]}}, w[10:0]};
                d.two_cycle = 1'b1;
            end
            8'b1110_0???: begin
                d.op = conditional_branch;
                d.target = pc + {{12{w[7]}}, w[7:0]};
                d.cond = 1'b1;
            end
            8'b1110_110?: begin
                d.op = absolute_call;
                d.fast = w[8];
                d.target = {12'h000, w[7:0]};
                d.two_word = 1'b1;
            end
            8'b1110_1111: begin
                d.op = absolute_jump;
                d.target = {12'h000, w[7:0]};
                d.two_word = 1'b1;
            end
            8'b0000_1???: d.op = literal_operation;
            8'b0000_0000: begin
                if (w[7:1] == 7'h09) begin
                    d.op = subroutine_return;
                    d.fast = w[0];
                    d.two_cycle = 1'b1;
                end else if (w[7:0] == 8'h00) begin
                    d.op = op_nop;
                end
            end
            default: d.op = op_other;
        endcase
        d.to_file = has_d & w[9];
        // Source reads pins instead of the output latch on ports
        d.use_pins = (has_d | bitmod) & is_port(d.file_addr);
        d.clr_prescaler = (d.to_file | bitmod) & (d.file_addr == TIMER_ADDR);
        decode_word = d;
    endfunction : decode_word

    function automatic decode_type nop_word();
        decode_type d;
        d = '0;
        d.valid = 1'b1;
        d.op = op_nop;
        nop_word = d;
    endfunction : nop_word

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    always_comb begin
        decode_type d;
        logic [31:0] rd;
        logic [1:0] rr;
        d = '0;
        rd = 32'h0000_0000;
        rr = `RESP_OKAY;
        st_nxt = st_r;
        st_nxt.out.valid = 1'b0;
        st_nxt.out.clr_prescaler = 1'b0;
        if (instr_valid) begin
            st_nxt.count = st_r.count + 32'h0000_0001;
            st_nxt.flush = 1'b0;
            st_nxt.cond_pending = 1'b0;
            unique case (st_r.phase)
                st_first: begin
                    if (st_r.flush || (st_r.cond_pending && cond_true)) begin
                        st_nxt.out = nop_word();
                    end else if (instr_word[15:12] == `PFX_SECOND) begin
                        st_nxt.out = nop_word();
                    end else begin
                        d = decode_word(instr_word, st_r.bank, pc_next);
                        if (d.two_word) begin
                            // Hold the first word; nothing issues until its operand arrives
                            st_nxt.out = d;
                            st_nxt.out.valid = 1'b0;
                            st_nxt.held = instr_word;
                            st_nxt.phase = st_operand;
                        end else begin
                            st_nxt.out = d;
                            st_nxt.flush = d.two_cycle;
                            st_nxt.cond_pending = d.cond;
                        end
                    end
                end
                st_operand: begin
                    st_nxt.phase = st_first;
                    if (instr_word[15:12] == `PFX_SECOND) begin
                        st_nxt.out.valid = 1'b1;
                        if (st_r.out.op == file_to_file_move) begin
                            st_nxt.out.move_dst = instr_word[11:0];
                            st_nxt.out.clr_prescaler = (instr_word[11:0] == TIMER_ADDR);
                        end else begin
                            st_nxt.out.target = {instr_word[11:0], st_r.held[7:0]};
                        end
                    end else begin
                        // Broken pair: drop the first word rather than guess an operand
                        st_nxt.out = nop_word();
                    end
                end
            endcase
        end
        // Write channel: address and data taken in either order
        if (awvalid && st_r.aw_rdy) begin
            st_nxt.aw_rdy = 1'b0;
            st_nxt.awaddr = awaddr;
        end
        if (wvalid && st_r.w_rdy) begin
            st_nxt.w_rdy = 1'b0;
            st_nxt.wdata = wdata;
            st_nxt.wstrb = wstrb;
        end
        if (!st_r.aw_rdy && !st_r.w_rdy && !st_r.bvalid) begin
            st_nxt.bvalid = 1'b1;
            unique case (st_r.awaddr)
                `OFS_CTRL: begin
                    st_nxt.bresp = `RESP_OKAY;
                    if (st_r.wstrb[0]) begin
                        st_nxt.bank = st_r.wdata[`CTRL_BANK_MSB:`CTRL_BANK_LSB];
                    end
                end
                `OFS_STATUS, `OFS_COUNT: st_nxt.bresp = `RESP_SLVERR;
                default: st_nxt.bresp = `RESP_DECERR;
            endcase
        end
        if (st_r.bvalid && bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.aw_rdy = 1'b1;
            st_nxt.w_rdy = 1'b1;
        end
        // Read channel: one word answered the cycle after the address
        unique case (araddr)
            `OFS_CTRL: rd = {28'h000_0000, st_r.bank};
            `OFS_STATUS: rd = {21'h00_0000, st_r.cond_pending, st_r.flush, st_r.phase, 1'b0, st_r.out.op};
            `OFS_COUNT: rd = st_r.count;
            default: rr = `RESP_DECERR;
        endcase
        if (arvalid && st_r.ar_rdy) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd;
            st_nxt.rresp = rr;
        end
        if (st_r.rvalid && rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.ar_rdy = 1'b1;
        end
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.phase <= st_first;
            st_r.bank <= `BANK_RESET;
            st_r.aw_rdy <= 1'b1;
            st_r.w_rdy <= 1'b1;
            st_r.ar_rdy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign awready = st_r.aw_rdy;
    assign wready = st_r.w_rdy;
    assign bvalid = st_r.bvalid;
    assign bresp = st_r.bresp;
    assign arready = st_r.ar_rdy;
    assign rvalid = st_r.rvalid;
    assign rdata = st_r.rdata;
    assign rresp = st_r.rresp;
    assign decoded = st_r.out;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    assign clean_first = instr_valid && (st_r.phase == st_first) && !st_r.flush
                         && !(st_r.cond_pending && cond_true) && (instr_word[15:12] != `PFX_SECOND);

    a_dest_select: assert property (
        clean_first && (instr_word[15:10] == 6'b001001) |=> decoded.valid && (decoded.to_file == $past(instr_word[9])))
        else $error("destination bit not followed");
    a_bank_select: assert property (
        clean_first && (instr_word[15:12] == 4'h5) && instr_word[8]
        |=> decoded.file_addr[11:8] == $past(st_r.bank))
        else $error("bank register not used");
    a_file_low_byte: assert property (
        clean_first && (instr_word[15:12] == 4'h9) |=> decoded.file_addr[7:0] == $past(instr_word[7:0]))
        else $error("file address low byte wrong");
    a_move_pair: assert property (
        st_r.phase == st_operand && instr_valid && instr_word[15:12] == `PFX_SECOND && st_r.out.op == file_to_file_move
        |=> decoded.valid && decoded.move_dst == $past(instr_word[11:0]) && decoded.flags == `FLAGS_NONE)
        else $error("move destination wrong");
    a_bit_field: assert property (
        clean_first && (instr_word[15:12] == 4'h8) |=> decoded.bit_pos == $past(instr_word[11:9]))
        else $error("bit position wrong");
    a_jump_target: assert property (
        st_r.phase == st_operand && instr_valid && instr_word[15:12] == `PFX_SECOND && st_r.out.op == absolute_jump
        |=> decoded.target == {$past(instr_word[11:0]), $past(st_r.held[7:0])})
        else $error("jump target wrong");
    a_fast_bit: assert property (
        clean_first && (instr_word[15:1] == 15'h0009) |=> decoded.fast == $past(instr_word[0]))
        else $error("fast bit lost");
    a_branch_flush: assert property (
        ((decoded.valid && decoded.op == unconditional_relative_branch && instr_valid)
         or (decoded.valid && decoded.op == unconditional_relative_branch && !instr_valid ##1 instr_valid))
        |=> decoded.valid && decoded.op == op_nop)
        else $error("branch second cycle not idle");
    a_lone_second: assert property (
        instr_valid && st_r.phase == st_first && instr_word[15:12] == `PFX_SECOND |=> decoded.op == op_nop)
        else $error("lone second word executed");
    a_logic_flags: assert property (
        decoded.valid && decoded.op inside {and_accumulator_file, xor_accumulator_file} |-> decoded.flags == `FLAGS_ZN)
        else $error("logic flags wrong");
    a_write_answer: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");

    c_two_word: cover property (decoded.valid && decoded.op == absolute_call);
    c_skip_taken: cover property (st_r.cond_pending && cond_true && instr_valid);
    c_port_rmw: cover property (decoded.valid && decoded.use_pins);
    c_timer_clear: cover property (decoded.clr_prescaler);
endmodule : instruction_decoder
`default_nettype wire

// ### tb/byte_bit_instruction_decoder_test.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
`default_nettype none
`include "decoder_consts.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module byte_bit_instruction_decoder_test;
    import decoder_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
    logic instr_valid, cond_true;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] instr_word, w;
    logic [19:0] pc_next;
    logic [7:0] f;
    decode_type decoded;
    int errors, compares, words;
    logic [7:0] hi [21] = '{8'h24, 8'h20, 8'h5C, 8'h58, 8'h54, 8'h14, 8'h10, 8'h18, 8'h1C, 8'h2C, 8'h3C,
                            8'h4C, 8'h48, 8'h62, 8'h64, 8'h60, 8'h34, 8'h30, 8'h44, 8'h40, 8'h02};
    instruction_decoder dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .instr_word, .instr_valid, .pc_next, .cond_true, .decoded);
    fetch_model fetch_u (.aclk, .instr_word, .instr_valid, .pc_next, .cond_true);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ----------------------------------------
    // Bus and stream tasks
    // ----------------------------------------
    function automatic logic hasd(int i);
        return i < 13 || (i > 15 && i < 20);
    endfunction : hasd
    function automatic logic [4:0] fl(int i);
        return i < 5 ? 5'h1F : i < 9 ? 5'h14 : i < 16 ? 5'h00 : i < 18 ? 5'h15 : i < 20 ? 5'h14 : 5'h00;
    endfunction : fl
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        logic aw, wd;
        aw = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        // Address and data may be taken on different edges
        do begin
            @(posedge aclk);
            aw = aw | awready;
            wd = wd | wready;
            if (aw) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end while (!(aw && wd));
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        `CHK(bresp, e)
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        `CHK(rdata, d)
        `CHK(rresp, e)
    endtask : axr
    task automatic dec(input logic [15:0] iw, input logic c, input op_type o, input logic v);
        fetch_u.issue(iw, c);
        words++;
        #1;
        `CHK(decoded.valid, v)
        if (v) `CHK(decoded.op, o)
    endtask : dec
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        errors++;
        end_sim();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`OFS_CTRL, 32'h0, `RESP_OKAY);
        wstrb <= 4'hF;
        axw(`OFS_CTRL, 32'h5, `RESP_OKAY);
        axr(`OFS_CTRL, 32'h5, `RESP_OKAY);
        axw(`OFS_STATUS, 32'h1, `RESP_SLVERR);
        axw(12'h010, 32'h1, `RESP_DECERR);
        axr(12'h00C, 32'h0, `RESP_DECERR);
        for (int i = 0; i < 21; i++) begin
            f = 8'(i * 12);
            w = {hi[i] | {6'h00, hasd(i) & i[0], i[1]}, f};
            dec(w, 1'b0, op_type'(i + 1), 1'b1);
            `CHK(decoded.file_addr, i[1] ? {4'h5, f} : (f < 8'h60 ? {4'h0, f} : {4'hF, f}))
            `CHK(decoded.to_file, hasd(i) & i[0])
            `CHK(decoded.flags, fl(i))
        end
        dec(16'h2680, 1'b0, add_accumulator_file, 1'b1);
        `CHK(decoded.use_pins, 1'b1)
        dec(16'h24D6, 1'b0, add_accumulator_file, 1'b1);
        `CHK(decoded.clr_prescaler, 1'b0)
        dec(16'h26D6, 1'b0, add_accumulator_file, 1'b1);
        `CHK(decoded.clr_prescaler, 1'b1)
        dec(16'h9A45, 1'b0, bit_modify, 1'b1);
        `CHK(decoded.bit_pos, 3'h5)
        dec(16'h8E45, 1'b0, bit_modify, 1'b1);
        `CHK(decoded.bit_pos, 3'h7)
        dec(16'h0E7F, 1'b0, literal_operation, 1'b1);
        `CHK(decoded.literal, 8'h7F)
        dec(16'hEF12, 1'b0, op_nop, 1'b0);
        dec(16'hF345, 1'b0, absolute_jump, 1'b1);
        `CHK(decoded.target, 20'h34512)
        dec(16'hED12, 1'b0, op_nop, 1'b0);
        dec(16'hF345, 1'b0, absolute_call, 1'b1);
        `CHK(decoded.fast, 1'b1)
        dec(16'hC123, 1'b0, op_nop, 1'b0);
        dec(16'hF456, 1'b0, file_to_file_move, 1'b1);
        `CHK({decoded.file_addr, decoded.move_dst, decoded.flags}, {12'h123, 12'h456, 5'h00})
        `CHK(decoded.two_word, 1'b1)
        dec(16'hF345, 1'b0, op_nop, 1'b1);
        dec(16'hD7FF, 1'b0, unconditional_relative_branch, 1'b1);
        `CHK({decoded.target, decoded.two_cycle}, {pc_next - 20'h00001, 1'b1})
        axr(`OFS_STATUS, 32'h0000_0200 | 32'(unconditional_relative_branch), `RESP_OKAY);
        dec(16'h2600, 1'b0, op_nop, 1'b1);
        dec(16'hE280, 1'b0, conditional_branch, 1'b1);
        `CHK(decoded.target, pc_next - 20'h00080)
        dec(16'h2600, 1'b1, op_nop, 1'b1);
        dec(16'h0013, 1'b0, subroutine_return, 1'b1);
        `CHK(decoded.fast, 1'b1)
        dec(16'h2600, 1'b0, op_nop, 1'b1);
        axr(`OFS_COUNT, 32'(words), `RESP_OKAY);
        end_sim();
    end
endmodule : byte_bit_instruction_decoder_test
`default_nettype wire

// ### tb/fetch_model.sv
// Program memory fetch unit model feeding the decoder
`timescale 1ns/10ps
`default_nettype none
module fetch_model (
    input wire logic aclk,
    output logic [15:0] instr_word,
    output logic instr_valid,
    output logic [19:0] pc_next,
    output logic cond_true
);
    initial begin
        instr_word = 16'h0000;
        instr_valid = 1'b0;
        pc_next = 20'h00100;
        cond_true = 1'b0;
    end
    // One word per call, held for one edge; idle bus shows the inverse so stale data never decodes
    task automatic issue(input logic [15:0] w, input logic c);
        @(posedge aclk);
        instr_word <= w;
        instr_valid <= 1'b1;
        cond_true <= c;
        pc_next <= pc_next + 20'h00001;
        @(posedge aclk);
        instr_valid <= 1'b0;
        instr_word <= ~w;
    endtask : issue
endmodule : fetch_model
`default_nettype wire
